//--- logic/pss_pkg.sv
/*
  Shared constants and types for the port state and standby control block.
  Assumes a 100 MHz system clock and an AHB-Lite register bus with 32-bit data.
*/
`default_nettype none

package pss_pkg;

  // ---------------------------------------------------------------
  // Processing states, one-hot
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_RESET  = 5'h01,
    ST_HWSTBY = 5'h02,
    ST_SWSTBY = 5'h04,
    ST_SLEEP  = 5'h08,
    ST_RUN    = 5'h10
  } pss_state_t;

  // ---------------------------------------------------------------
  // Operating modes on the mode pins
  // ---------------------------------------------------------------
  localparam logic [1:0] MODE_EXP1   = 2'h1;
  localparam logic [1:0] MODE_EXP2   = 2'h2;
  localparam logic [1:0] MODE_SINGLE = 2'h3;

  // ---------------------------------------------------------------
  // Pin map: general port, address port, strobes
  // ---------------------------------------------------------------
  localparam int NPIN     = 19;
  localparam int GP_LO    = 0;
  localparam int AD_LO    = 8;
  localparam int STB_LO   = 16;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [4:0] OFS_DATA   = 5'h00;
  localparam logic [4:0] OFS_DIR    = 5'h04;
  localparam logic [4:0] OFS_PULLUP = 5'h08;
  localparam logic [4:0] OFS_SYSCTL = 5'h0c;
  localparam logic [4:0] OFS_PWRCMD = 5'h10;
  localparam logic [4:0] OFS_STATUS = 5'h14;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int SYS_RAM_EN_BIT = 0;
  localparam int SYS_FNEN_BIT   = 1;
  localparam int SYS_CLKDIR_BIT = 2;
  localparam int CMD_SLEEP_BIT  = 0;
  localparam int CMD_SWSTBY_BIT = 1;
  localparam logic [18:0] PORT_RST  = 19'h00000;
  localparam logic        RAM_ENABLE_RST  = 1'b1;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam logic [3:0] RST_LEAD_CYC = 4'ha;

endpackage

`default_nettype wire

//--- logic/pss_pin_cell.sv
/*
  One port pin: decides drive, level and pull-up from the processing state.
  Assumes the caller applies any forced level for the state and mode.
*/
`timescale 1ns/100ps
`default_nettype none

module pss_pin_cell (
  // Clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  // State and settings
  input  wire pss_pkg::pss_state_t state,
  input  wire logic              ddr,
  input  wire logic              out_bit,
  input  wire logic              pull_bit,
  input  wire logic              fn_en,
  input  wire logic              fn_out,
  input  wire logic              force_en,
  input  wire logic              force_val,
  // Pin
  output logic                   pin_o,
  output logic                   pin_oe_n,
  output logic                   pullup_en
);

  logic hold_val_reg;
  logic hold_drv_reg;
  logic drv;
  logic val;

  // ---------------------------------------------------------------
  // Last driven level, caught while running
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hold_val_reg <= 1'b0;
      hold_drv_reg <= 1'b0;
    end else if (state == pss_pkg::ST_RUN) begin
      hold_drv_reg <= fn_en | ddr;
      hold_val_reg <= fn_en ? fn_out : out_bit;
    end
  end

  always_comb begin
    drv = 1'b0;
    val = 1'b0;
    case (state)
      pss_pkg::ST_HWSTBY: begin
        drv = 1'b0; // RULE11
      end
      pss_pkg::ST_RESET: begin
        drv = force_en;
        val = force_val;
      end
      pss_pkg::ST_SWSTBY: begin
        // Peripherals are reinitialised, so only forced levels, direction and data count
        drv = force_en | ddr; // RULE3
        val = force_en ? force_val : out_bit;
      end
      pss_pkg::ST_SLEEP: begin
        // Address outputs keep the last address here
        drv = force_en | hold_drv_reg; // RULE1 RULE2
        val = force_en ? force_val : hold_val_reg;
      end
      pss_pkg::ST_RUN: begin
        drv = fn_en | ddr;
        val = fn_en ? fn_out : out_bit;
      end
      default: begin
        drv = 1'b0;
        val = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Registered pin outputs
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_o     <= 1'b0;
      pin_oe_n  <= 1'b1;
      pullup_en <= 1'b0;
    end else begin
      pin_o     <= val;
      pin_oe_n  <= ~drv;
      pullup_en <= pull_bit & ~ddr & ~drv & (state != pss_pkg::ST_RESET)
                   & (state != pss_pkg::ST_HWSTBY); // RULE1
    end
  end

endmodule

`default_nettype wire

//--- logic/pss_top.sv
/*
  Port state and standby control: processing-state sequencer, AHB-Lite
  registers, per-pin state cells, clock-output pin and RAM retention check.
  Assumes chip_rst_n, hw_standby_n, wake_evt and mode pins are synchronous
  to hclk, and that the pad ring merges hclk onto the clock pin when
  clk_pin_sel is high.
*/
// Chosen here: the AHB-Lite register port and the register addresses.
// Contract
// RULE1 - Kept state: inputs float with pull-up if enabled, outputs hold last level
// RULE2 - Kept address outputs continue driving the last accessed address
// RULE3 - Software standby reinitialises peripherals; pins follow direction and data only
// RULE4 - For RAM retention, chip reset goes low ten cycles before standby
// RULE5 - Chip reset stays low until standby goes low
// RULE6 - Without RAM retention, standby may come without a prior chip reset
// RULE7 - Chip reset goes low about 100 ns before standby is released
// RULE8 - Single-chip clock pin: direction set drives clock in sleep and run
// RULE9 - Single-chip software standby: clock pin high if direction set, else floats
// RULE10 - Expanded modes: strobes high in reset, standby, sleep; bus strobes running
// RULE11 - Hardware standby floats every pin, clock and strobe pins included
`timescale 1ns/100ps
`default_nettype none

module pss_top (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Chip control pins
  input  wire logic        chip_rst_n,
  input  wire logic        hw_standby_n,
  input  wire logic        wake_evt,
  input  wire logic [1:0]  mode,
  // Core side of the external bus and peripherals
  input  wire logic [7:0]  cpu_addr,
  input  wire logic        cpu_addr_stb_n,
  input  wire logic        cpu_wr_n,
  input  wire logic        cpu_rd_n,
  input  wire logic [7:0]  periph_out,
  // Port pins
  input  wire logic [18:0] pin_i,
  output logic [18:0]      pin_o,
  output logic [18:0]      pin_oe_n,
  output logic [18:0]      pullup_en,
  // Clock pin
  output logic             clk_pin_sel,
  output logic             clk_pin_o,
  output logic             clk_pin_oe_n,
  // Status
  output logic             ram_retain
);

  pss_pkg::pss_state_t state_reg;
  logic [18:0] port_data_out;
  logic [18:0] port_dir;
  logic [18:0] pullup_ctrl;
  logic        ram_enable;
  logic        fn_en_reg;
  logic        clk_dir_reg;
  logic        sleep_req;
  logic        swstby_req;
  logic        wr_pend_reg;
  logic [4:0]  wr_addr_reg;
  logic [3:0]  rst_cnt_reg;
  logic        expanded;
  logic        m1;
  logic        m2;
  logic [18:0] fn_en_v;
  logic [18:0] fn_out_v;
  logic [18:0] force_en_v;
  logic [18:0] force_val_v;
  logic        addr_ph;
  logic [31:0] rdata_next;

  assign expanded = (mode != pss_pkg::MODE_SINGLE);
  assign m1       = (mode == pss_pkg::MODE_EXP1);
  assign m2       = (mode == pss_pkg::MODE_EXP2);

  // ---------------------------------------------------------------
  // Processing-state sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= pss_pkg::ST_RESET;
    end else if (!hw_standby_n) begin
      state_reg <= pss_pkg::ST_HWSTBY; // RULE11 RULE6
    end else begin
      case (state_reg)
        pss_pkg::ST_HWSTBY: begin
          // Leaving standby always restarts through reset
          state_reg <= pss_pkg::ST_RESET; // RULE7
        end
        pss_pkg::ST_RESET: begin
          if (chip_rst_n) begin
            state_reg <= pss_pkg::ST_RUN;
          end
        end
        pss_pkg::ST_RUN: begin
          if (!chip_rst_n) begin
            state_reg <= pss_pkg::ST_RESET;
          end else if (swstby_req) begin
            state_reg <= pss_pkg::ST_SWSTBY;
          end else if (sleep_req) begin
            state_reg <= pss_pkg::ST_SLEEP;
          end
        end
        pss_pkg::ST_SWSTBY, pss_pkg::ST_SLEEP: begin
          if (!chip_rst_n) begin
            state_reg <= pss_pkg::ST_RESET;
          end else if (wake_evt) begin
            state_reg <= pss_pkg::ST_RUN;
          end
        end
        default: begin
          state_reg <= pss_pkg::ST_RESET;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // RAM retention check on standby entry
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rst_cnt_reg <= 4'h0;
    end else if (chip_rst_n) begin
      rst_cnt_reg <= 4'h0;
    end else if (rst_cnt_reg != pss_pkg::RST_LEAD_CYC) begin
      rst_cnt_reg <= rst_cnt_reg + 4'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ram_retain <= 1'b0;
    end else if (!hw_standby_n && state_reg != pss_pkg::ST_HWSTBY) begin
      // Reset must already be low, and long enough, as standby falls
      ram_retain <= ram_enable & ~chip_rst_n
                    & (rst_cnt_reg == pss_pkg::RST_LEAD_CYC); // RULE4 RULE5
    end else if (state_reg == pss_pkg::ST_RUN) begin
      ram_retain <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // AHB-Lite slave: zero wait states, always OKAY
  // ---------------------------------------------------------------
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign addr_ph   = hsel & htrans[1] & hready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 5'h00;
    end else begin
      wr_pend_reg <= addr_ph & hwrite;
      wr_addr_reg <= haddr[4:0];
    end
  end

  always_comb begin
    rdata_next = 32'h0000_0000;
    case (haddr[4:0])
      pss_pkg::OFS_DATA:   rdata_next = {13'h0000, port_data_out};
      pss_pkg::OFS_DIR:    rdata_next = {13'h0000, port_dir};
      pss_pkg::OFS_PULLUP: rdata_next = {13'h0000, pullup_ctrl};
      pss_pkg::OFS_SYSCTL: rdata_next = {29'h0000_0000, clk_dir_reg, fn_en_reg, ram_enable};
      pss_pkg::OFS_STATUS: rdata_next = {5'h00, pin_i, ram_retain, mode, state_reg};
      default:             rdata_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_ph && !hwrite) begin
      hrdata <= rdata_next;
    end
  end

  // ---------------------------------------------------------------
  // Registers; chip reset returns port settings to reset values
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_data_out <= pss_pkg::PORT_RST;
      port_dir      <= pss_pkg::PORT_RST;
      pullup_ctrl   <= pss_pkg::PORT_RST;
      clk_dir_reg   <= 1'b0;
      ram_enable    <= pss_pkg::RAM_ENABLE_RST;
    end else if (state_reg == pss_pkg::ST_RESET || state_reg == pss_pkg::ST_HWSTBY) begin
      port_data_out <= pss_pkg::PORT_RST;
      port_dir      <= pss_pkg::PORT_RST;
      pullup_ctrl   <= pss_pkg::PORT_RST;
      clk_dir_reg   <= 1'b0;
    end else if (wr_pend_reg) begin
      case (wr_addr_reg)
        pss_pkg::OFS_DATA:   port_data_out <= hwdata[18:0];
        pss_pkg::OFS_DIR:    port_dir      <= hwdata[18:0];
        pss_pkg::OFS_PULLUP: pullup_ctrl   <= hwdata[18:0];
        pss_pkg::OFS_SYSCTL: begin
          ram_enable  <= hwdata[pss_pkg::SYS_RAM_EN_BIT];
          clk_dir_reg <= hwdata[pss_pkg::SYS_CLKDIR_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  // Peripheral pin function is dropped on entry to software standby
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fn_en_reg <= 1'b0;
    end else if (state_reg != pss_pkg::ST_RUN && state_reg != pss_pkg::ST_SLEEP) begin
      fn_en_reg <= 1'b0; // RULE3
    end else if (wr_pend_reg && wr_addr_reg == pss_pkg::OFS_SYSCTL) begin
      fn_en_reg <= hwdata[pss_pkg::SYS_FNEN_BIT];
    end
  end

  // Power commands are one-cycle pulses, no storage
  assign sleep_req  = wr_pend_reg & (wr_addr_reg == pss_pkg::OFS_PWRCMD)
                      & hwdata[pss_pkg::CMD_SLEEP_BIT];
  assign swstby_req = wr_pend_reg & (wr_addr_reg == pss_pkg::OFS_PWRCMD)
                      & hwdata[pss_pkg::CMD_SWSTBY_BIT];

  // ---------------------------------------------------------------
  // Per-pin function and forced levels
  // ---------------------------------------------------------------
  assign fn_en_v  = {{3{expanded}}, {8{expanded}}, {8{fn_en_reg}}};
  assign fn_out_v = {cpu_rd_n, cpu_wr_n, cpu_addr_stb_n, cpu_addr, periph_out};

  always_comb begin
    force_en_v  = 19'h00000;
    force_val_v = 19'h00000;
    // Address pins low in reset and standby in mode 1, or in standby if output in mode 2
    if ((state_reg == pss_pkg::ST_RESET && m1) || state_reg == pss_pkg::ST_SWSTBY) begin
      force_en_v[15:8] = m1 ? 8'hff : (m2 ? port_dir[15:8] : 8'h00);
    end
    if (expanded && (state_reg == pss_pkg::ST_RESET || state_reg == pss_pkg::ST_SWSTBY
                     || state_reg == pss_pkg::ST_SLEEP)) begin
      force_en_v[18:16]  = 3'h7; // RULE10
      force_val_v[18:16] = 3'h7;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < pss_pkg::NPIN; gi++) begin : g_pin
      pss_pin_cell u_cell (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .state     (state_reg),
        .ddr       (port_dir[gi]),
        .out_bit   (port_data_out[gi]),
        .pull_bit  (pullup_ctrl[gi]),
        .fn_en     (fn_en_v[gi]),
        .fn_out    (fn_out_v[gi]),
        .force_en  (force_en_v[gi]),
        .force_val (force_val_v[gi]),
        .pin_o     (pin_o[gi]),
        .pin_oe_n  (pin_oe_n[gi]),
        .pullup_en (pullup_en[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // Clock-output pin
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_pin_sel  <= 1'b0;
      clk_pin_o    <= 1'b0;
      clk_pin_oe_n <= 1'b1;
    end else begin
      case (state_reg)
        pss_pkg::ST_RESET: begin
          clk_pin_sel  <= expanded;
          clk_pin_o    <= 1'b0;
          clk_pin_oe_n <= ~expanded;
        end
        pss_pkg::ST_SWSTBY: begin
          clk_pin_sel  <= 1'b0; // RULE9
          clk_pin_o    <= 1'b1;
          clk_pin_oe_n <= ~(expanded | clk_dir_reg);
        end
        pss_pkg::ST_SLEEP, pss_pkg::ST_RUN: begin
          clk_pin_sel  <= expanded | clk_dir_reg; // RULE8
          clk_pin_o    <= 1'b0;
          clk_pin_oe_n <= ~(expanded | clk_dir_reg);
        end
        default: begin
          clk_pin_sel  <= 1'b0; // RULE11
          clk_pin_o    <= 1'b0;
          clk_pin_oe_n <= 1'b1;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

//--- dv/pss_checker.sv
/*
  Concurrent checks on the pin, clock-pin and retention outputs of pss_top.
  Assumes the mode pins only change while hresetn is low.
*/
`timescale 1ns/100ps
`default_nettype none

module pss_checker (
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Chip control pins
  input wire logic        chip_rst_n,
  input wire logic        hw_standby_n,
  input wire logic [1:0]  mode,
  // Observed outputs
  input wire logic [18:0] pin_o,
  input wire logic [18:0] pin_oe_n,
  input wire logic [18:0] pullup_en,
  input wire logic        clk_pin_sel,
  input wire logic        clk_pin_o,
  input wire logic        clk_pin_oe_n,
  input wire logic        ram_retain
);
  // ---------------------------------------------------------------
  // Helper: consecutive low samples of chip reset
  // ---------------------------------------------------------------
  logic [3:0] low_cnt_reg;

  // Saturates so a long reset never wraps back below ten
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_cnt_reg <= 4'h0;
    end else if (chip_rst_n) begin
      low_cnt_reg <= 4'h0;
    end else if (low_cnt_reg != 4'hf) begin
      low_cnt_reg <= low_cnt_reg + 4'h1;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_retain_lead: assert property ($rose(ram_retain) |->
    low_cnt_reg >= 4'ha && !$past(hw_standby_n)) else $error("retention without reset lead");
  a_hwstby_float: assert property (!hw_standby_n [*2] |=> (&pin_oe_n) && clk_pin_oe_n
    && !clk_pin_sel && pullup_en == 19'h0) else $error("pins driven in hardware standby");
  a_pullup_undriven: assert property ((pullup_en & ~pin_oe_n) == 19'h0)
    else $error("pull-up on a driven pin");
  a_clk_sel_drive: assert property (clk_pin_sel |-> !clk_pin_oe_n)
    else $error("clock passed to an undriven pin");
  a_clk_static_high: assert property (mode == pss_pkg::MODE_SINGLE && !clk_pin_sel
    && !clk_pin_oe_n |-> clk_pin_o) else $error("static clock pin level not high");
  a_rst_strobes: assert property ((mode != pss_pkg::MODE_SINGLE && !chip_rst_n
    && hw_standby_n) [*2] |=> pin_o[18:16] == 3'h7 && pin_oe_n[18:16] == 3'h0)
    else $error("strobes not high in reset");
  a_addr_driven: assert property ((mode == pss_pkg::MODE_EXP1 && hw_standby_n) [*2]
    |=> pin_oe_n[15:8] == 8'h00) else $error("address pins released");

  c_retain: cover property ($rose(ram_retain));
  c_clk_run: cover property (clk_pin_sel);
  c_clk_high: cover property (!clk_pin_sel && !clk_pin_oe_n && clk_pin_o);
endmodule

`default_nettype wire

//--- dv/pss_ext_ctrl.sv
/*
  Model of the outside controller driving the chip reset and standby pins.
  Assumes its tasks are started just after a clock edge or off it.
*/
`timescale 1ns/100ps
`default_nettype none

module pss_ext_ctrl (
  // Clock
  input  wire logic hclk,
  // Pins into the device
  output logic      chip_rst_n,
  output logic      hw_standby_n
);
  initial begin
    chip_rst_n = 1'b1;
    hw_standby_n = 1'b1;
  end

  task automatic rst(input logic v);
    chip_rst_n <= v;
  endtask

  // With keep, reset stays low through entry; without lead RAM is not protected
  task automatic enter(input logic keep);
    if (keep) begin
      chip_rst_n <= 1'b0;
      // One spare cycle: a call on the edge would fall short of ten
      repeat (11) @(posedge hclk);
    end
    hw_standby_n <= 1'b0;
  endtask

  // Ten cycles at 100 MHz give the reset lead before release
  task automatic leave();
    chip_rst_n <= 1'b0;
    repeat (10) @(posedge hclk);
    hw_standby_n <= 1'b1;
    repeat (2) @(posedge hclk);
    chip_rst_n <= 1'b1;
  endtask
endmodule

`default_nettype wire

//--- dv/port_state_standby_control_tb.sv
/*
  Self-checking bench for pss_top: AHB-Lite register tasks, state sequences.
  Assumes zero-wait slave behaviour may change; every wait is bounded.
*/
`timescale 1ns/100ps
`default_nettype none

`define CHK(a, e) \
  begin \
    check_count++; \
    if ((a) !== (e)) begin \
      fails++; \
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, (a), (e)); \
    end \
  end

module port_state_standby_control_tb;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, wake_evt;
  logic        cpu_addr_stb_n, cpu_wr_n, cpu_rd_n, chip_rst_n, hw_standby_n;
  logic        clk_pin_sel, clk_pin_o, clk_pin_oe_n, ram_retain;
  logic [1:0]  htrans, mode;
  logic [2:0]  hsize;
  logic [7:0]  cpu_addr, periph_out;
  logic [18:0] pin_i, pin_o, pin_oe_n, pullup_en;
  logic [31:0] haddr, hwdata, hrdata, q;
  int          fails, check_count;

  pss_ext_ctrl u_ext (.hclk, .chip_rst_n, .hw_standby_n);
  pss_top u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .chip_rst_n, .hw_standby_n,
    .wake_evt, .mode, .cpu_addr, .cpu_addr_stb_n, .cpu_wr_n, .cpu_rd_n, .periph_out, .pin_i,
    .pin_o, .pin_oe_n, .pullup_en, .clk_pin_sel, .clk_pin_o, .clk_pin_oe_n, .ram_retain);

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic end_sim();
    if (fails == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic rdy();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 20) begin
        fails++;
        end_sim();
      end
      @(posedge hclk);
    end
  endtask

  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {27'h0, a};
    rdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    rdy();
    q = hrdata;
  endtask

  // Off-edge sampling avoids racing the registered outputs
  task automatic settle(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask

  task automatic wake();
    wake_evt <= 1'b1;
    settle(1);
    wake_evt <= 1'b0;
    settle(3);
  endtask

  function automatic logic [31:0] st(input logic [4:0] s, input logic rr);
    return {5'h0, pin_i, rr, mode, s};
  endfunction

  // ---------------------------------------------------------------
  // Clock, watchdog, sequence
  // ---------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  initial begin
    #300000;
    fails++;
    end_sim();
  end

  initial begin
    {hresetn, hsel, haddr, htrans, hwrite, hwdata, wake_evt} = '0;
    {hsize, mode, cpu_addr, periph_out} = {3'h2, pss_pkg::MODE_SINGLE, 8'h5a, 8'h3c};
    {cpu_addr_stb_n, cpu_wr_n, cpu_rd_n, pin_i} = {3'b010, 19'h2a5c3};
    fails = 0;
    check_count = 0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    settle(2);
    bus(0, pss_pkg::OFS_SYSCTL, 0);
    `CHK({hresp, hreadyout, q}, {2'b01, 32'h1})
    bus(0, pss_pkg::OFS_STATUS, 0);
    `CHK(q, st(5'h10, 1'b0))
    bus(0, 5'h18, 0);
    `CHK(q, 32'h0)
    bus(1, pss_pkg::OFS_DATA, 32'ha5);
    bus(1, pss_pkg::OFS_DIR, 32'hf0);
    bus(1, pss_pkg::OFS_PULLUP, 32'h0f);
    bus(1, pss_pkg::OFS_SYSCTL, 32'h7);
    settle(2);
    `CHK({clk_pin_sel, clk_pin_oe_n, pin_o[7:0]}, 10'h23c)
    bus(1, pss_pkg::OFS_PWRCMD, 32'h1);
    settle(3);
    periph_out <= 8'hc3;
    settle(2);
    `CHK({clk_pin_sel, clk_pin_oe_n, pin_o[7:0]}, 10'h23c)
    wake();
    bus(1, pss_pkg::OFS_PWRCMD, 32'h3);
    settle(3);
    bus(0, pss_pkg::OFS_STATUS, 0);
    `CHK(q, st(5'h04, 1'b0))
    settle(0);
    `CHK({clk_pin_sel, clk_pin_oe_n, clk_pin_o}, 3'b001)
    `CHK({pin_oe_n[7:0], pin_o[7:4], pullup_en[7:0]}, 20'h0fa0f)
    wake();
    bus(1, pss_pkg::OFS_SYSCTL, 32'h1);
    settle(2);
    `CHK(clk_pin_oe_n, 1'b1)
    bus(1, pss_pkg::OFS_PWRCMD, 32'h2);
    settle(3);
    `CHK(clk_pin_oe_n, 1'b1)
    wake();
    u_ext.enter(1'b1);
    settle(3);
    `CHK({pin_oe_n, clk_pin_oe_n, ram_retain}, 21'h1fffff)
    u_ext.leave();
    settle(3);
    bus(0, pss_pkg::OFS_DIR, 0);
    `CHK(q, 32'h0)
    bus(0, pss_pkg::OFS_STATUS, 0);
    `CHK(q, st(5'h10, 1'b0))
    u_ext.enter(1'b0);
    settle(3);
    `CHK({pin_oe_n[18:16], ram_retain}, 4'he)
    u_ext.leave();
    settle(3);
    for (int m = 1; m < 3; m++) begin
      hresetn <= 1'b0;
      mode <= m[1:0];
      settle(2);
      hresetn <= 1'b1;
      u_ext.rst(1'b0);
      settle(3);
      `CHK({pin_o[18:16], pin_oe_n[18:16]}, 6'h38)
      u_ext.rst(1'b1);
      settle(3);
      `CHK(pin_o[18:16], 3'b010)
      if (m == 1) `CHK(pin_o[15:8], 8'h5a)
      bus(1, pss_pkg::OFS_PWRCMD, 32'h1);
      settle(3);
      cpu_addr <= 8'h66;
      settle(2);
      `CHK(pin_o[18:16], 3'h7)
      if (m == 1) `CHK(pin_o[15:8], 8'h5a)
      wake();
      bus(1, pss_pkg::OFS_DIR, 32'h0f00);
      bus(1, pss_pkg::OFS_PWRCMD, 32'h2);
      settle(3);
      `CHK(pin_o[18:16], 3'h7)
      `CHK({pin_oe_n[15:8], pin_o[11:8]}, (m == 1) ? 12'h000 : 12'hf00)
      wake();
      cpu_addr <= 8'h5a;
    end
    end_sim();
  end
endmodule

bind pss_top pss_checker u_chk (.hclk, .hresetn, .chip_rst_n, .hw_standby_n, .mode,
  .pin_o, .pin_oe_n, .pullup_en, .clk_pin_sel, .clk_pin_o, .clk_pin_oe_n, .ram_retain);

`default_nettype wire
